// [rtl/ump_cell_port.sv]
// slave-side multi-phy cell port, 8 or 16 bit, one phy address
// assumes link clocks are slow enough to be sampled by mclk_i (80 ns vs 5 ns)
`default_nettype none
// Behaviour
// - drop tx words between cells
// - check tx parity on link clock edge
// - idle after cell until start and enable
// - sample tx data on tx clock rise
// - drive tx cell available, tristateable
// - drive rx data only when enabled, selected
// - generate rx parity with each word
// - rx start flag only on first word
// - rx outputs change only after rx clock rise
// - data ready the cycle after enable
// - rx drivers on only after enabled cycle
// - drive rx cell available, tristateable
module ump_cell_port #(
    parameter int unsigned BUF_D = ump_pkg::BUF_DEPTH
) (
    input wire logic mclk_i,                    // core clock, 200 MHz
    input wire logic sys_rst_i,                 // synchronous reset, high
    input wire logic bus16_i,                   // 1: 16-bit bus, 0: 8-bit
    input wire logic par_odd_i,                 // 1: odd parity, 0: even
    input wire logic [4:0] phy_addr_i,          // own phy address
    input wire ump_pkg::ump_txpin_s tx_pin_i,   // transmit pins from master
    output logic txclav_o,                      // tx cell available
    output logic txclav_oe_o,                   // tx cell available driven
    input wire ump_pkg::ump_rxpin_s rx_pin_i,   // receive pins from master
    output logic [15:0] rxdata_o,               // rx data bus
    output logic rxsoc_o,                       // rx start of cell
    output logic rxpar_o,                       // rx parity
    output logic rxdata_oe_o,                   // rx data, soc, parity driven
    output logic rxclav_o,                      // rx cell available
    output logic rxclav_oe_o,                   // rx cell available driven
    output logic cell_valid_o,                  // received tx word ready
    output ump_pkg::ump_word_s cell_word_o,     // received tx word
    input wire logic cell_ready_i,              // user takes tx word
    output logic tx_par_err_o,                  // parity error pulse
    output logic tx_lost_o,                     // word lost to full buffer
    input wire logic rx_valid_i,                // user offers rx word
    input wire ump_pkg::ump_word_s rx_word_i,   // rx word to send
    output logic rx_ready_o                     // rx word taken
);
    import ump_pkg::*;

    ump_txpin_s tx_s1_q;
    ump_txpin_s tx_s2_q;
    logic tx_clk_prev_q;
    ump_rxpin_s rx_s1_q;
    ump_rxpin_s rx_s2_q;
    logic rx_clk_prev_q;
    logic tx_edge;
    logic rx_edge;
    ump_tx_e tx_st_q;
    logic [5:0] tx_cnt_q;
    logic [5:0] tx_last;
    logic tx_sel_q;
    logic tx_start;
    logic tx_push;
    logic tx_par_bad;
    logic buf_in_ready;
    ump_word_s tx_word;
    logic [15:0] tx_act;
    logic rx_sel_q;
    ump_word_s rx_hold_q;
    logic rx_hold_v_q;
    logic rx_take;
    logic [15:0] rx_act;

    // ones count parity of the active lanes
    function automatic logic par_of(input logic [15:0] d, input logic wide, input logic odd);
        logic p;
        p = wide ? ^d : ^d[7:0];
        return p ^ odd;
    endfunction

    // two-flop synchronisers; a third flop on each clock finds the edge
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            tx_s1_q <= '0;
            tx_s2_q <= '0;
            tx_clk_prev_q <= 1'b0;
            rx_s1_q <= '0;
            rx_s2_q <= '0;
            rx_clk_prev_q <= 1'b0;
        end else begin
            tx_s1_q <= tx_pin_i;
            tx_s2_q <= tx_s1_q;
            tx_clk_prev_q <= tx_s2_q.clk;
            rx_s1_q <= rx_pin_i;
            rx_s2_q <= rx_s1_q;
            rx_clk_prev_q <= rx_s2_q.clk;
        end
    end

    // data travels with its clock, so the edge sees settled data
    assign tx_edge = tx_s2_q.clk && !tx_clk_prev_q;
    assign rx_edge = rx_s2_q.clk && !rx_clk_prev_q;

    // ---- transmit side ----
    // 8-bit mode uses the low lane only; bit 7 is then the top bit
    assign tx_act = bus16_i ? tx_s2_q.data : {8'h00, tx_s2_q.data[7:0]};
    assign tx_last = bus16_i ? CELL_MORE_W16 : CELL_MORE_W8;
    assign tx_start = tx_edge && !tx_s2_q.enb_n && tx_s2_q.soc && tx_sel_q;
    // words outside a cell are simply not pushed
    assign tx_push = (tx_st_q == TX_IDLE) ? tx_start
                   : (tx_edge && !tx_s2_q.enb_n);
    assign tx_par_bad = par_of(tx_act, bus16_i, par_odd_i) != tx_s2_q.par;
    assign tx_word = '{soc: (tx_st_q == TX_IDLE), data: tx_act};

    // selection latched while enable is high, as in multi-phy polling
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            tx_sel_q <= 1'b0;
        end else if (tx_edge && tx_s2_q.enb_n) begin
            tx_sel_q <= (tx_s2_q.addr == phy_addr_i);
        end
    end

    // cell framing: start word then a fixed count, then back to idle
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            tx_st_q <= TX_IDLE;
            tx_cnt_q <= '0;
        end else begin
            case (tx_st_q)
                TX_IDLE: begin
                    if (tx_start) begin
                        tx_st_q <= TX_CELL;
                        tx_cnt_q <= '0;
                    end
                end
                TX_CELL: begin
                    if (tx_push) begin
                        tx_cnt_q <= tx_cnt_q + CNT_ONE;
                        if (tx_cnt_q + CNT_ONE == tx_last) begin
                            tx_st_q <= TX_IDLE;
                        end
                    end
                end
                default: begin
                    tx_st_q <= TX_IDLE;
                end
            endcase
        end
    end

    // error and loss pulses, one core cycle each
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            tx_par_err_o <= 1'b0;
            tx_lost_o <= 1'b0;
        end else begin
            tx_par_err_o <= tx_push && tx_par_bad;
            tx_lost_o <= tx_push && !buf_in_ready;
        end
    end

    // cell available: only a polled own address drives the shared wire;
    // the buffer is small, so a stalled user shows as no cell space
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            txclav_o <= 1'b0;
            txclav_oe_o <= 1'b0;
        end else if (tx_edge) begin
            txclav_o <= buf_in_ready && cell_ready_i;
            txclav_oe_o <= (tx_s2_q.addr == phy_addr_i);
        end
    end

    ump_fifo2 #(
        .WIDTH($bits(ump_word_s)),
        .DEPTH(BUF_D)
    ) u_txbuf (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .in_valid_i(tx_push),
        .in_data_i(tx_word),
        .in_ready_o(buf_in_ready),
        .out_valid_o(cell_valid_o),
        .out_data_o(cell_word_o),
        .out_ready_i(cell_ready_i)
    );

    // ---- receive side ----
    assign rx_ready_o = !rx_hold_v_q;
    assign rx_take = rx_edge && !rx_s2_q.enb_n && rx_sel_q && rx_hold_v_q;
    assign rx_act = bus16_i ? rx_hold_q.data : {8'h00, rx_hold_q.data[7:0]};

    // one-word holding stage fed by the user
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            rx_hold_q <= '0;
            rx_hold_v_q <= 1'b0;
        end else if (rx_valid_i && !rx_hold_v_q) begin
            rx_hold_q <= rx_word_i;
            rx_hold_v_q <= 1'b1;
        end else if (rx_take) begin
            rx_hold_v_q <= 1'b0;
        end
    end

    // rx selection latched while enable is high
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            rx_sel_q <= 1'b0;
        end else if (rx_edge && rx_s2_q.enb_n) begin
            rx_sel_q <= (rx_s2_q.addr == phy_addr_i);
        end
    end

    // drivers follow an enabled, selected cycle; updated on link edges only
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            rxdata_oe_o <= 1'b0;
        end else if (rx_edge) begin
            rxdata_oe_o <= !rx_s2_q.enb_n && rx_sel_q;
        end
    end

    // new word, start flag and parity together; an empty stage repeats
    // the last word with the start flag low rather than inventing one
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            rxdata_o <= '0;
            rxsoc_o <= 1'b0;
            rxpar_o <= par_of(16'h0000, 1'b1, 1'b1) ^ 1'b1;
        end else if (rx_take) begin
            rxdata_o <= rx_act;
            rxsoc_o <= rx_hold_q.soc;
            rxpar_o <= par_of(rx_act, bus16_i, par_odd_i);
        end else if (rx_edge && !rx_s2_q.enb_n) begin
            rxsoc_o <= 1'b0;
            rxpar_o <= par_of(rxdata_o, bus16_i, par_odd_i);
        end
    end

    // rx cell available for own address polls
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            rxclav_o <= 1'b0;
            rxclav_oe_o <= 1'b0;
        end else if (rx_edge) begin
            rxclav_o <= rx_hold_v_q;
            rxclav_oe_o <= (rx_s2_q.addr == phy_addr_i);
        end
    end

    // ---- checks ----
    property p_tx_gap;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (tx_st_q == TX_IDLE) && !tx_start |-> !tx_push;
    endproperty
    a_tx_gap: assert property (p_tx_gap) else $error("word taken between cells");

    property p_tx_end;
        @(posedge mclk_i) disable iff (sys_rst_i)
        tx_push && (tx_st_q == TX_CELL) && (tx_cnt_q + CNT_ONE == tx_last)
        |=> (tx_st_q == TX_IDLE) && !tx_push;
    endproperty
    a_tx_end: assert property (p_tx_end) else $error("cell did not end");

    property p_tx_par;
        @(posedge mclk_i) disable iff (sys_rst_i)
        tx_push && tx_par_bad |=> tx_par_err_o;
    endproperty
    a_tx_par: assert property (p_tx_par) else $error("parity error missed");

    property p_tx_edge;
        @(posedge mclk_i) disable iff (sys_rst_i)
        tx_edge |=> !tx_edge;
    endproperty
    a_tx_edge: assert property (p_tx_edge) else $error("link edges too close");

    property p_txclav_sel;
        @(posedge mclk_i) disable iff (sys_rst_i)
        $changed(txclav_oe_o) |-> $past(tx_edge);
    endproperty
    a_txclav_sel: assert property (p_txclav_sel) else $error("clav drive off edge");

    property p_rx_oe;
        @(posedge mclk_i) disable iff (sys_rst_i)
        $rose(rxdata_oe_o) |-> $past(rx_edge && !rx_s2_q.enb_n && rx_sel_q);
    endproperty
    a_rx_oe: assert property (p_rx_oe) else $error("rx driven unselected");

    property p_rx_par;
        @(posedge mclk_i) disable iff (sys_rst_i)
        rx_take |=> rxpar_o == par_of(rxdata_o, bus16_i, par_odd_i);
    endproperty
    a_rx_par: assert property (p_rx_par) else $error("rx parity wrong");

    property p_rx_soc;
        @(posedge mclk_i) disable iff (sys_rst_i)
        rx_edge && !rx_s2_q.enb_n && !rx_take |=> !rxsoc_o;
    endproperty
    a_rx_soc: assert property (p_rx_soc) else $error("stale start flag");

    property p_rx_sync;
        @(posedge mclk_i) disable iff (sys_rst_i)
        $changed(rxdata_o) || $changed(rxdata_oe_o) |-> $past(rx_edge);
    endproperty
    a_rx_sync: assert property (p_rx_sync) else $error("rx changed off edge");

    property p_own_addr;
        @(posedge mclk_i) disable iff (sys_rst_i)
        rx_edge ##1 rxclav_oe_o |-> $past(rx_s2_q.addr) == phy_addr_i;
    endproperty
    a_own_addr: assert property (p_own_addr) else $error("foreign address answered");

    c_tx_cell: cover property (@(posedge mclk_i) disable iff (sys_rst_i)
        $fell(tx_st_q == TX_CELL));
    c_rx_soc: cover property (@(posedge mclk_i) disable iff (sys_rst_i)
        $rose(rxsoc_o) && rxdata_oe_o);
    c_tx_full: cover property (@(posedge mclk_i) disable iff (sys_rst_i)
        !buf_in_ready ##1 buf_in_ready);
endmodule
`default_nettype wire

// [rtl/ump_fifo2.sv]
// small first-in first-out buffer held in flip-flops
// assumes both sides on the core clock; depth is a power of two
`default_nettype none
module ump_fifo2 #(
    parameter int unsigned WIDTH = 17,
    parameter int unsigned DEPTH = 2
) (
    input wire logic mclk_i,              // core clock
    input wire logic sys_rst_i,           // synchronous reset, high
    input wire logic in_valid_i,          // word offered
    input wire logic [WIDTH-1:0] in_data_i, // word offered
    output logic in_ready_o,              // room for a word
    output logic out_valid_o,             // word available
    output logic [WIDTH-1:0] out_data_o,  // head word, from flops
    input wire logic out_ready_i          // consumer takes head
);
    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    // sized to the count, so the depth itself is never truncated away
    localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0] wr_q;
    logic [PW-1:0] rd_q;
    logic [PW:0] cnt_q;
    logic push;
    logic pop;

    // honest flags straight from the occupancy count
    assign in_ready_o = (cnt_q != FULL_CNT);
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o = mem_q[rd_q];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // storage is written only, never reset; the count guards reads
    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    // pointers and count
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + PW'(1);
            end
            if (pop) begin
                rd_q <= rd_q + PW'(1);
            end
            cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// [rtl/ump_pkg.sv]
// shared constants, pin bundles and state types for the cell port
// assumes a single core clock; link pins are sampled, never used as clocks
`default_nettype none
package ump_pkg;
    // core clock period and documented link clock ceilings
    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned TXCLK_MAX8_MHZ = 52;
    localparam int unsigned TXCLK_MAX16_MHZ = 33;
    // fastest link half period in core cycles, rounded down, at least one
    localparam int unsigned LINK_HALF_PS = 1000000 / (TXCLK_MAX8_MHZ * 2);
    localparam int unsigned LINK_HALF_CYC =
        (LINK_HALF_PS / CLK_PERIOD_PS) < 1 ? 1 : (LINK_HALF_PS / CLK_PERIOD_PS);
    // words following the start-of-cell word
    localparam logic [5:0] CELL_MORE_W16 = 6'h1A;
    localparam logic [5:0] CELL_MORE_W8 = 6'h34;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned ADDR_W = 5;
    localparam int unsigned BUF_DEPTH = 2;
    localparam logic [5:0] CNT_ONE = 6'h01;

    // one cell word with its start marker
    typedef struct packed {
        logic soc;
        logic [DATA_W-1:0] data;
    } ump_word_s;

    // transmit pins as they arrive from the master
    typedef struct packed {
        logic clk;
        logic enb_n;
        logic soc;
        logic par;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } ump_txpin_s;

    // receive control pins from the master
    typedef struct packed {
        logic clk;
        logic enb_n;
        logic [ADDR_W-1:0] addr;
    } ump_rxpin_s;

    // transmit cell state, gray along idle -> cell
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_CELL = 2'b01
    } ump_tx_e;
endpackage
`default_nettype wire

// [testbench/ump_atm_master.sv]
// atm-layer master model: drives the transmit and receive link pins
// assumes the bench calls one task at a time; link clocks stand still between calls
`default_nettype none
module ump_atm_master (
    input wire logic par_odd_i,              // 1: odd parity
    output var ump_pkg::ump_txpin_s tx_pin_o, // transmit pins
    output var ump_pkg::ump_rxpin_s rx_pin_o  // receive pins
);
    timeunit 1ns;
    timeprecision 100ps;
    import ump_pkg::*;

    logic [15:0] last_q;

    // pins idle with both enables off
    initial begin
        last_q = 16'h0000;
        tx_pin_o = '0;
        tx_pin_o.enb_n = 1'b1;
        rx_pin_o = '0;
        rx_pin_o.enb_n = 1'b1;
    end

    // one transmit link cycle of 80 ns; pins settle 40 ns before the rise
    task automatic tx_cyc(input logic enb_n, input logic soc, input logic bad,
                          input logic [4:0] addr, input logic [15:0] data);
        tx_pin_o.enb_n = enb_n;
        tx_pin_o.soc = soc;
        tx_pin_o.addr = addr;
        // an idle bus shows the inverse of its last word, never a stale copy
        tx_pin_o.data = enb_n ? ~last_q : data;
        if (!enb_n) last_q = data;
        tx_pin_o.par = ^tx_pin_o.data ^ par_odd_i ^ bad;
        #40 tx_pin_o.clk = 1'b1;
        #40 tx_pin_o.clk = 1'b0;
    endtask

    // one receive link cycle; the bench always precedes a low enable with a high one
    task automatic rx_cyc(input logic enb_n, input logic [4:0] addr);
        rx_pin_o.enb_n = enb_n;
        rx_pin_o.addr = addr;
        #40 rx_pin_o.clk = 1'b1;
        #40 rx_pin_o.clk = 1'b0;
    endtask
endmodule
`default_nettype wire

// [testbench/ump_cell_port_bench.sv]
// self-checking bench for the cell port: random cells in, random words back out
// assumes the master model beside it and the design's default buffer depth
`default_nettype none
module ump_cell_port_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import ump_pkg::*;

    logic mclk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic bus16_i = 1'b1;
    logic par_odd_i = 1'b1;
    logic [4:0] phy_addr_i = 5'h00;
    ump_txpin_s tx_pin;
    ump_rxpin_s rx_pin;
    logic txclav_o, txclav_oe_o, rxsoc_o, rxpar_o, rxdata_oe_o, rxclav_o, rxclav_oe_o;
    logic [15:0] rxdata_o;
    logic cell_valid_o, tx_par_err_o, tx_lost_o, rx_ready_o;
    ump_word_s cell_word_o;
    logic cell_ready_i = 1'b1;
    logic rx_valid_i = 1'b0;
    ump_word_s rx_word_i = '0;
    logic stall = 1'b0;
    logic rnd_on = 1'b0;
    logic [31:0] seed = 32'hA93B1D77;
    logic [31:0] seed_rdy = 32'hA93B1D77;
    int num_errors = 0;
    int samples_checked = 0;
    int n_perr = 0;
    int n_lost = 0;
    ump_word_s exp_q[$];

    ump_atm_master master (.par_odd_i(par_odd_i), .tx_pin_o(tx_pin), .rx_pin_o(rx_pin));

    ump_cell_port dut (.mclk_i, .sys_rst_i, .bus16_i, .par_odd_i, .phy_addr_i,
        .tx_pin_i(tx_pin), .txclav_o, .txclav_oe_o, .rx_pin_i(rx_pin), .rxdata_o, .rxsoc_o,
        .rxpar_o, .rxdata_oe_o, .rxclav_o, .rxclav_oe_o, .cell_valid_o, .cell_word_o,
        .cell_ready_i, .tx_par_err_o, .tx_lost_o, .rx_valid_i, .rx_word_i, .rx_ready_o);

    initial forever #2.5 mclk_i = ~mclk_i;

    // xorshift step; each stream keeps its own state so process order cannot matter
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    function automatic logic par_f(input logic [15:0] d);
        return ^d ^ par_odd_i;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // user side pops at random while rnd_on is set, every cycle otherwise, unless stalled on purpose
    always begin
        @(posedge mclk_i);
        #1;
        seed_rdy = xs(seed_rdy);
        cell_ready_i = ~stall & (seed_rdy[0] | ~rnd_on);
    end

    // every popped word must be the next one expected; pulses are counted
    // looked at mid-cycle, where valid and ready stand as the next rise sees them
    always @(negedge mclk_i) begin
        if (!sys_rst_i) begin
            if (cell_valid_o === 1'b1 && cell_ready_i) begin
                if (exp_q.size() == 0) check(1, 0);
                else check(cell_word_o, exp_q.pop_front());
            end
            if (tx_par_err_o === 1'b1) n_perr++;
            if (tx_lost_o === 1'b1) n_lost++;
        end
    end

    // four modes at most ~10 us each; a generous margin stops a hang
    initial begin
        #400000;
        num_errors++;
        end_sim();
    end

    initial begin
        logic [15:0] d;
        logic [4:0] oth;
        int n;
        for (int m = 0; m < 4; m++) begin
            seed = xs(seed);
            bus16_i = m[0];
            par_odd_i = m[1];
            phy_addr_i = seed[4:0];
            oth = ~seed[4:0];
            n = bus16_i ? 27 : 53;
            sys_rst_i = 1'b1;
            tick(20);
            sys_rst_i = 1'b0;
            tick(4);
            n_perr = 0;
            n_lost = 0;
            check({txclav_o, txclav_oe_o, rxdata_o, rxsoc_o, rxpar_o,
                   rxdata_oe_o, rxclav_o, cell_valid_o, rx_ready_o}, 24'h000001);
            // select, then a stray word before any start is dropped
            master.tx_cyc(1'b1, 1'b0, 1'b0, phy_addr_i, 16'h0000);
            check({txclav_oe_o, txclav_o}, 2'b11);
            master.tx_cyc(1'b0, 1'b0, 1'b0, phy_addr_i, 16'h1234);
            // one whole cell with a bad parity word and an idle cycle inside
            rnd_on = 1'b1;
            for (int i = 0; i < n; i++) begin
                seed = xs(seed);
                d = bus16_i ? seed[15:0] : {8'h00, seed[7:0]};
                if (i == 5) master.tx_cyc(1'b1, 1'b0, 1'b0, phy_addr_i, seed[31:16]);
                exp_q.push_back({i == 0, d});
                master.tx_cyc(1'b0, i == 0, i == 3, phy_addr_i, d);
            end
            master.tx_cyc(1'b0, 1'b0, 1'b0, phy_addr_i, 16'h00A5);
            rnd_on = 1'b0;
            tick(20);
            check(exp_q.size(), 0);
            check(n_perr, 1);
            // another address: no clav drive and no words taken
            master.tx_cyc(1'b1, 1'b0, 1'b0, oth, 16'h0000);
            check(txclav_oe_o, 1'b0);
            for (int i = 0; i < 3; i++) master.tx_cyc(1'b0, i == 0, 1'b0, oth, 16'h5A5A);
            // receiver stalls: two words buffered, the rest reported lost
            master.tx_cyc(1'b1, 1'b0, 1'b0, phy_addr_i, 16'h0000);
            stall = 1'b1;
            for (int i = 0; i < n; i++) begin
                if (i < BUF_DEPTH) exp_q.push_back({i == 0, 16'(i)});
                master.tx_cyc(1'b0, i == 0, 1'b0, phy_addr_i, 16'(i));
            end
            check(txclav_o, 1'b0);
            check(n_lost, n - BUF_DEPTH);
            stall = 1'b0;
            tick(20);
            check(exp_q.size(), 0);
            // receive side: a start word then a plain word
            for (int k = 0; k < 2; k++) begin
                seed = xs(seed);
                d = bus16_i ? seed[15:0] : {8'h00, seed[7:0]};
                rx_valid_i = 1'b1;
                rx_word_i = {k == 0, seed[15:0]};
                tick(1);
                rx_valid_i = 1'b0;
                check(rx_ready_o, 1'b0);
                master.rx_cyc(1'b1, phy_addr_i);
                check({rxdata_oe_o, rxclav_oe_o, rxclav_o}, 3'b011);
                master.rx_cyc(1'b0, phy_addr_i);
                check({rxdata_oe_o, rxsoc_o, rxpar_o, rxdata_o},
                      {1'b1, k == 0, par_f(d), d});
                check(rx_ready_o, 1'b1);
            end
            master.rx_cyc(1'b1, oth);
            master.rx_cyc(1'b0, oth);
            check({rxdata_oe_o, rxclav_oe_o, rxclav_o}, 3'b000);
            $display("mode %0d done", m);
        end
        end_sim();
    end
endmodule
`default_nettype wire
